// >>> core/pwm_period_duty_generator.sv
// PWM generator top: APB registers, period timer and output pin latch
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_defs.svh"
// Summary of operation
// R1 - Period is (limit plus one) times four oscillator periods times prescale
// R2 - Timer count equal to limit clears the count on next increment
// R3 - One clock after that increment the pin sets, unless the duty is zero
// R4 - That same increment copies the duty into the shadow register
// R5 - Duty is low byte as upper eight bits, control bits 5:4 below
// R6 - High time is duty times oscillator period times prescale
// R7 - New duty written any time takes effect after current period
// R8 - Shadow duty register is read-only to software in PWM mode
// R9 - Shadow register plus two-bit latch double buffer the duty
// R10 - Pin clears when shadow duty equals count with two fine bits
// R11 - Duty longer than period never matches; pin stays high
// R12 - Software sets limit, duty, pin direction, prescale, then PWM mode
// R13 - Software clears direction bit 3 to make the pin an output
// R14 - Prescaler divides by 1, 4 or 16
// R15 - Clearing module control forces the output latch low
// R16 - Outside PWM mode pin is not driven nor shadow loaded at period end
module pwm_period_duty_generator
  import pwm_pkg::*;
(
  input  wire logic [`PWM_ADDR_W-1:0] paddr,
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  output logic                        pwm_pin_o,
  output logic                        pwm_pin_oe
);

  pwm_core_if cif ();

  logic [7:0]            tcount_r;
  logic [`PWM_TC_W-1:0]  tctrl_r;
  logic [7:0]            dlow_r;
  logic [`PWM_MC_W-1:0]  mctrl_r;
  logic [7:0]            dir_r;
  logic [7:0]            limit_r;
  logic                  pready_r;
  logic [31:0]           prdata_r;
  logic                  pslverr_r;
  logic                  pin_r;
  logic                  pin_oe_r;
  logic                  pend_r;
  logic [7:0]            rd_val;
  reg_sel_t              sel;
  logic                  setup;
  logic                  wr_acc;
  logic                  pwm_mode;
  logic                  wrap;
  logic                  mc_zero_wr;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  function automatic reg_sel_t decode(input logic [`PWM_ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    if (a[1:0] != 2'b00 || a[`PWM_ADDR_W-1:10] != 2'b00) begin
      decode = SEL_NONE;
    end else begin
      unique case (idx)
        `PWM_IDX_GINT:   decode = SEL_GINT;
        `PWM_IDX_PIFLAG: decode = SEL_PIFLAG;
        `PWM_IDX_TCOUNT: decode = SEL_TCOUNT;
        `PWM_IDX_TCTRL:  decode = SEL_TCTRL;
        `PWM_IDX_DLOW:   decode = SEL_DLOW;
        `PWM_IDX_DHIGH:  decode = SEL_DHIGH;
        `PWM_IDX_MCTRL:  decode = SEL_MCTRL;
        `PWM_IDX_DIR:    decode = SEL_DIR;
        `PWM_IDX_PIEN:   decode = SEL_PIEN;
        `PWM_IDX_LIMIT:  decode = SEL_LIMIT;
        default:         decode = SEL_NONE;
      endcase
    end
  endfunction : decode

  assign sel    = decode(paddr);
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pready_r && pwrite && !pslverr_r;

  always_comb begin
    unique case (sel)
      SEL_TCOUNT: rd_val = tcount_r;
      SEL_TCTRL:  rd_val = {1'b0, tctrl_r};
      SEL_DLOW:   rd_val = dlow_r;
      SEL_DHIGH:  rd_val = cif.shadow_q[9:2];
      SEL_MCTRL:  rd_val = {2'b00, mctrl_r};
      SEL_DIR:    rd_val = dir_r;
      SEL_LIMIT:  rd_val = limit_r;
      default:    rd_val = `PWM_RST_ZERO;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      pready_r  <= 1'b1;
      prdata_r  <= {24'h00_0000, rd_val};
      pslverr_r <= (sel == SEL_NONE);
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign pready  = pready_r;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tctrl_r <= `PWM_TC_W'(`PWM_RST_ZERO);
    end else if (wr_acc && sel == SEL_TCTRL) begin
      tctrl_r <= pwdata[`PWM_TC_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dlow_r <= `PWM_RST_ZERO;
    end else if (wr_acc && sel == SEL_DLOW) begin
      dlow_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mctrl_r <= `PWM_MC_W'(`PWM_RST_ZERO);
    end else if (wr_acc && sel == SEL_MCTRL) begin
      mctrl_r <= pwdata[`PWM_MC_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_r <= `PWM_RST_DIR;
    end else if (wr_acc && sel == SEL_DIR) begin
      dir_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_r <= `PWM_RST_LIMIT;
    end else if (wr_acc && sel == SEL_LIMIT) begin
      limit_r <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Period timer
  // ----------------------------------------------------------------
  assign pwm_mode   = (mctrl_r[`PWM_MC_MODE_HI:`PWM_MC_MODE_MID] == `PWM_MODE_PWM); // R16
  assign wrap       = (tcount_r == limit_r);
  assign mc_zero_wr = wr_acc && sel == SEL_MCTRL && pwdata[`PWM_MC_W-1:0] == `PWM_MC_W'(`PWM_RST_ZERO);

  assign cif.run     = tctrl_r[`PWM_TC_ON];
  assign cif.ps_sel  = prescale_t'(tctrl_r[`PWM_TC_PS_HI:`PWM_TC_PS_LO]); // R14
  assign cif.pre_clr = wr_acc && (sel == SEL_TCOUNT || sel == SEL_TCTRL);
  assign cif.tcount  = tcount_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcount_r <= `PWM_RST_ZERO;
    end else if (wr_acc && sel == SEL_TCOUNT) begin
      tcount_r <= pwdata[7:0];
    end else if (cif.tick) begin
      tcount_r <= wrap ? `PWM_RST_ZERO : tcount_r + 8'h01; // R1 R2
    end
  end

  pwm_time_base u_time_base (
    .pclk    (pclk),
    .presetn (presetn),
    .cif     (cif)
  );

  // ----------------------------------------------------------------
  // Duty buffering and output latch
  // ----------------------------------------------------------------
  assign cif.period_end = cif.tick && wrap && !cif.pre_clr;
  assign cif.load_en    = pwm_mode; // R16
  assign cif.duty_new   = {dlow_r, mctrl_r[`PWM_MC_DUTY_HI:`PWM_MC_DUTY_LO]}; // R5
  assign cif.shadow_we  = wr_acc && sel == SEL_DHIGH && !pwm_mode; // R8
  assign cif.shadow_wd  = pwdata[7:0];

  pwm_duty_buffer u_duty_buffer (
    .pclk    (pclk),
    .presetn (presetn),
    .cif     (cif)
  );

  // Aligns the set with the fine position so high time is exactly duty steps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= cif.period_end && pwm_mode;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_r <= 1'b0;
    end else if (mc_zero_wr) begin
      pin_r <= 1'b0; // R15
    end else if (pwm_mode) begin
      if (cif.match) begin
        pin_r <= 1'b0; // R6 R10 R11
      end else if (pend_r && cif.shadow_q != 10'h000) begin
        pin_r <= 1'b1; // R3
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe_r <= 1'b0;
    end else begin
      pin_oe_r <= pwm_mode && !dir_r[`PWM_DIR_PIN]; // R13 R16
    end
  end

  assign pwm_pin_o  = pin_r;
  assign pwm_pin_oe = pin_oe_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [15:0] per_cnt_r;
  logic        steady_r;
  logic [15:0] per_exp;

  always_comb begin
    unique case (cif.ps_sel)
      PS_DIV1:             per_exp = 16'(({8'h00, limit_r} + 16'h0001) * `PWM_Q_PER_INSTR * `PWM_PS_F1);
      PS_DIV4:             per_exp = 16'(({8'h00, limit_r} + 16'h0001) * `PWM_Q_PER_INSTR * `PWM_PS_F4);
      PS_DIV16, PS_DIV16B: per_exp = 16'(({8'h00, limit_r} + 16'h0001) * `PWM_Q_PER_INSTR * `PWM_PS_F16);
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_r <= 16'h0000;
      steady_r  <= 1'b0;
    end else begin
      per_cnt_r <= pend_r ? 16'h0001 : per_cnt_r + 16'h0001;
      steady_r  <= (wr_acc || !pwm_mode) ? 1'b0 : (pend_r ? 1'b1 : steady_r);
    end
  end

  sequence s_wrap_tick;
    cif.tick && wrap && !cif.pre_clr;
  endsequence

  property p_period;
    @(posedge pclk) disable iff (!presetn) (pend_r && steady_r) |-> per_cnt_r == per_exp;
  endproperty
  a_period: assert property (p_period) else $error("period length wrong"); // R1

  property p_wrap;
    @(posedge pclk) disable iff (!presetn) s_wrap_tick |=> tcount_r == `PWM_RST_ZERO;
  endproperty
  a_wrap: assert property (p_wrap) else $error("timer not cleared at limit"); // R2

  property p_set;
    @(posedge pclk) disable iff (!presetn)
      (s_wrap_tick and pwm_mode && cif.duty_new != 10'h000 && !wr_acc) ##1 !wr_acc |=> pin_r;
  endproperty
  a_set: assert property (p_set) else $error("pin not set at period start"); // R3

  property p_latch;
    @(posedge pclk) disable iff (!presetn)
      (s_wrap_tick and pwm_mode) |=> cif.shadow_q == $past(cif.duty_new);
  endproperty
  a_latch: assert property (p_latch) else $error("duty not latched at period end"); // R4

  property p_readonly;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && sel == SEL_DHIGH && pwm_mode && !cif.period_end) |=> $stable(cif.shadow_q);
  endproperty
  a_readonly: assert property (p_readonly) else $error("shadow duty written in PWM mode"); // R8

  property p_clear;
    @(posedge pclk) disable iff (!presetn) (pwm_mode && cif.match) |=> !pin_r;
  endproperty
  a_clear: assert property (p_clear) else $error("pin not cleared on duty match"); // R10

  property p_long;
    @(posedge pclk) disable iff (!presetn)
      (pin_r && pwm_mode && !wr_acc && tcount_r <= limit_r && cif.shadow_q > {limit_r, 2'b11}) |=> pin_r;
  endproperty
  a_long: assert property (p_long) else $error("pin cleared with overlong duty"); // R11

  property p_mc_zero;
    @(posedge pclk) disable iff (!presetn) mc_zero_wr |=> !pin_r ##1 !pin_oe_r;
  endproperty
  a_mc_zero: assert property (p_mc_zero) else $error("output latch not forced low"); // R15

  property p_off;
    @(posedge pclk) disable iff (!presetn) !pwm_mode |=> !pin_oe_r;
  endproperty
  a_off: assert property (p_off) else $error("pin driven outside PWM mode"); // R16

endmodule : pwm_period_duty_generator
`default_nettype wire

// >>> pkg/pwm_defs.svh
// Register indices, field positions, reset values and timing counts
`ifndef PWM_DEFS_SVH
`define PWM_DEFS_SVH

// Register indices; byte address is four times the index
`define PWM_ADDR_W        12
`define PWM_IDX_GINT      8'h0b
`define PWM_IDX_PIFLAG    8'h0c
`define PWM_IDX_TCOUNT    8'h11
`define PWM_IDX_TCTRL     8'h12
`define PWM_IDX_DLOW      8'h15
`define PWM_IDX_DHIGH     8'h16
`define PWM_IDX_MCTRL     8'h17
`define PWM_IDX_DIR       8'h86
`define PWM_IDX_PIEN      8'h8c
`define PWM_IDX_LIMIT     8'h92

// Field positions
`define PWM_MC_DUTY_HI    5
`define PWM_MC_DUTY_LO    4
`define PWM_MC_MODE_HI    3
`define PWM_MC_MODE_MID   2
`define PWM_MC_W          6
`define PWM_TC_W          7
`define PWM_TC_ON         2
`define PWM_TC_PS_HI      1
`define PWM_TC_PS_LO      0
`define PWM_DIR_PIN       3
`define PWM_MODE_PWM      2'b11

// Reset values
`define PWM_RST_ZERO      8'h00
`define PWM_RST_LIMIT     8'hff
`define PWM_RST_DIR       8'hff

// Timing: oscillator period, quarter cycles per instruction, prescale factors
`define PWM_CLK_NS        10
`define PWM_TOSC_NS       10
`define PWM_TOSC_CYC      ((`PWM_TOSC_NS + `PWM_CLK_NS - 1) / `PWM_CLK_NS)
`define PWM_Q_PER_INSTR   4
`define PWM_PS_F1         1
`define PWM_PS_F4         4
`define PWM_PS_F16        16
`define PWM_PS_LAST1      6'(`PWM_Q_PER_INSTR * `PWM_PS_F1 * `PWM_TOSC_CYC - 1)
`define PWM_PS_LAST4      6'(`PWM_Q_PER_INSTR * `PWM_PS_F4 * `PWM_TOSC_CYC - 1)
`define PWM_PS_LAST16     6'(`PWM_Q_PER_INSTR * `PWM_PS_F16 * `PWM_TOSC_CYC - 1)

`endif

// >>> pkg/pwm_pkg.sv
// Types shared by the PWM generator modules
package pwm_pkg;

  typedef enum logic [1:0] {
    PS_DIV1   = 2'b00,
    PS_DIV4   = 2'b01,
    PS_DIV16  = 2'b10,
    PS_DIV16B = 2'b11
  } prescale_t;

  typedef enum logic [3:0] {
    SEL_NONE   = 4'h0,
    SEL_GINT   = 4'h1,
    SEL_PIFLAG = 4'h2,
    SEL_TCOUNT = 4'h3,
    SEL_TCTRL  = 4'h4,
    SEL_DLOW   = 4'h5,
    SEL_DHIGH  = 4'h6,
    SEL_MCTRL  = 4'h7,
    SEL_DIR    = 4'h8,
    SEL_PIEN   = 4'h9,
    SEL_LIMIT  = 4'ha
  } reg_sel_t;

endpackage : pwm_pkg

// >>> pkg/pwm_core_if.sv
// Signals between the control block, time base and duty buffer
`timescale 1ns/1ps
`default_nettype none
interface pwm_core_if;
  import pwm_pkg::*;
  logic       run;
  prescale_t  ps_sel;
  logic       pre_clr;
  logic       tick;
  logic [1:0] sub_phase;
  logic [7:0] tcount;
  logic       load_en;
  logic       period_end;
  logic [9:0] duty_new;
  logic       shadow_we;
  logic [7:0] shadow_wd;
  logic [9:0] shadow_q;
  logic       match;

  modport base (input run, ps_sel, pre_clr, output tick, sub_phase);
  modport buffer (input load_en, period_end, duty_new, shadow_we, shadow_wd, tcount, sub_phase,
                  output shadow_q, match);
  modport ctl (output run, ps_sel, pre_clr, tcount, load_en, period_end, duty_new, shadow_we, shadow_wd,
               input tick, sub_phase, shadow_q, match);
endinterface : pwm_core_if
`default_nettype wire

// >>> core/pwm_time_base.sv
// Quarter-cycle and prescale divider giving the timer increment enable
`timescale 1ns/1ps
`default_nettype none
`include "pwm_defs.svh"
module pwm_time_base
  import pwm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  pwm_core_if.base cif
);

  logic [5:0] pre_r;
  logic [5:0] last;

  function automatic logic [5:0] ps_last(input prescale_t ps);
    unique case (ps)
      PS_DIV1:            ps_last = `PWM_PS_LAST1;
      PS_DIV4:            ps_last = `PWM_PS_LAST4;
      PS_DIV16, PS_DIV16B: ps_last = `PWM_PS_LAST16;
    endcase
  endfunction : ps_last

  assign last     = ps_last(cif.ps_sel);
  assign cif.tick = cif.run && (pre_r == last); // R14

  always_comb begin
    unique case (cif.ps_sel)
      PS_DIV1:             cif.sub_phase = pre_r[1:0];
      PS_DIV4:             cif.sub_phase = pre_r[3:2];
      PS_DIV16, PS_DIV16B: cif.sub_phase = pre_r[5:4];
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 6'h00;
    end else if (cif.pre_clr) begin
      pre_r <= 6'h00;
    end else if (cif.tick) begin
      pre_r <= 6'h00;
    end else if (cif.run) begin
      pre_r <= pre_r + 6'h01;
    end
  end

  sequence s_div1_run;
    (cif.tick && cif.ps_sel == PS_DIV1) ##1 (cif.run && !cif.pre_clr && cif.ps_sel == PS_DIV1) [*4];
  endsequence

  property p_div1;
    @(posedge pclk) disable iff (!presetn) s_div1_run |-> cif.tick;
  endproperty
  a_div1: assert property (p_div1) else $error("divide by one tick spacing wrong"); // R14

  property p_div4;
    @(posedge pclk) disable iff (!presetn)
      (cif.tick && cif.ps_sel == PS_DIV4) |=> (!cif.tick || cif.ps_sel != PS_DIV4) [*8];
  endproperty
  a_div4: assert property (p_div4) else $error("divide by four ticks too close"); // R14

endmodule : pwm_time_base
`default_nettype wire

// >>> core/pwm_duty_buffer.sv
// Double-buffered duty value and its match against the fine timer position
`timescale 1ns/1ps
`default_nettype none
module pwm_duty_buffer
  import pwm_pkg::*;
(
  input wire logic   pclk,
  input wire logic   presetn,
  pwm_core_if.buffer cif
);

  logic [9:0] shadow_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_r <= 10'h000;
    end else if (cif.load_en && cif.period_end) begin
      shadow_r <= cif.duty_new; // R4 R7 R9
    end else if (cif.shadow_we) begin
      shadow_r[9:2] <= cif.shadow_wd;
    end
  end

  assign cif.shadow_q = shadow_r;
  assign cif.match    = (shadow_r == {cif.tcount, cif.sub_phase}); // R10

  property p_hold;
    @(posedge pclk) disable iff (!presetn) (cif.load_en && !cif.period_end) |=> $stable(shadow_r);
  endproperty
  a_hold: assert property (p_hold) else $error("active duty changed mid-period"); // R7

endmodule : pwm_duty_buffer
`default_nettype wire

// >>> test/pwm_load_model.sv
// Load on the PWM pin: pull-down, measures high time and period
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model (
  input  wire logic        pclk,
  input  wire logic        pin_o,
  input  wire logic        pin_oe,
  output logic             level,
  output logic [31:0]      rises,
  output logic [31:0]      falls,
  output logic [31:0]      hi_len,
  output logic [31:0]      per_len
);
  logic        prev_r = 1'b0;
  logic [31:0] cyc_r  = 32'h0;
  logic [31:0] hi_r   = 32'h0;

  // Released pin is pulled low
  assign level = pin_oe ? pin_o : 1'b0;

  initial begin
    rises   = 32'h0;
    falls   = 32'h0;
    hi_len  = 32'h0;
    per_len = 32'h0;
  end

  always @(posedge pclk) begin
    prev_r <= level;
    if (level && !prev_r) begin
      per_len <= cyc_r;
      rises   <= rises + 1;
      cyc_r   <= 32'h1;
      hi_r    <= 32'h1;
    end else begin
      cyc_r <= cyc_r + 1;
      if (level) hi_r <= hi_r + 1;
    end
    if (!level && prev_r) begin
      hi_len <= hi_r;
      falls  <= falls + 1;
    end
  end
endmodule : pwm_load_model
`default_nettype wire

// >>> test/pwm_period_duty_generator_test.sv
// Self-checking bench for the PWM generator
`timescale 1ns/1ps
`default_nettype none
`include "pwm_defs.svh"
module pwm_period_duty_generator_test;
  import pwm_pkg::*;
  logic [11:0] paddr;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, pwm_pin_o, pwm_pin_oe, level;
  logic [31:0] rises, falls, hi_len, per_len;
  int          err_total, total_checks, seed;
  logic [7:0]  rd;
  logic        er;
  logic [31:0] r0;
  logic [7:0]  lim;
  logic [9:0]  dut;

  pwm_period_duty_generator pwm_period_duty_generator_i (.paddr(paddr), .pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pwm_pin_o(pwm_pin_o), .pwm_pin_oe(pwm_pin_oe));
  pwm_load_model pwm_load_model_i (.pclk(pclk), .pin_o(pwm_pin_o), .pin_oe(pwm_pin_oe), .level(level),
    .rises(rises), .falls(falls), .hi_len(hi_len), .per_len(per_len));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic int ps_f(input logic [1:0] c);
    return (c == 2'b00) ? `PWM_PS_F1 : (c == 2'b01) ? `PWM_PS_F4 : `PWM_PS_F16;
  endfunction : ps_f

  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tmo;
    err_total++;
    finish_test();
  endtask : tmo

  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) tmo();
    rd = prdata[7:0];
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
    check(er, 1'b0);
  endtask : wr

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rd, exp);
  endtask : rdc

  task automatic cfg(input logic [7:0] l, input logic [9:0] d, input logic [1:0] ps);
    wr(`PWM_IDX_MCTRL, 8'h00);
    wr(`PWM_IDX_LIMIT, l);
    // Count left above a smaller limit would run the full 8-bit range first
    wr(`PWM_IDX_TCOUNT, 8'h00);
    wr(`PWM_IDX_DLOW, d[9:2]);
    wr(`PWM_IDX_MCTRL, {2'b00, d[1:0], 4'h0});
    wr(`PWM_IDX_DIR, 8'hf7);
    wr(`PWM_IDX_TCTRL, {5'h00, 1'b1, ps});
    wr(`PWM_IDX_MCTRL, {2'b00, d[1:0], 4'hc});
  endtask : cfg

  task automatic wait_ev(ref logic [31:0] cnt, input logic [31:0] target);
    int n;
    n = 0;
    while (cnt < target && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 5000) tmo();
    #1;
  endtask : wait_ev

  task automatic meas(input int per, input int hi);
    wait_ev(rises, rises + 3);
    check(per_len, per);
    check(hi_len, hi);
  endtask : meas

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 98420;
    err_total = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    check(pwm_pin_oe, 1'b0);
    rdc(`PWM_IDX_TCOUNT, `PWM_RST_ZERO);
    rdc(`PWM_IDX_TCTRL, `PWM_RST_ZERO);
    rdc(`PWM_IDX_DLOW, `PWM_RST_ZERO);
    rdc(`PWM_IDX_MCTRL, `PWM_RST_ZERO);
    rdc(`PWM_IDX_DIR, `PWM_RST_DIR);
    rdc(`PWM_IDX_LIMIT, `PWM_RST_LIMIT);
    apb(1'b0, 8'h20, 8'h00);
    check(er, 1'b1);
    // Random period and duty for every prescale code
    for (int c = 0; c < 4; c++) begin
      lim = 8'({$random(seed)} % 8);
      dut = 10'(1 + {$random(seed)} % (4 * lim + 3));
      cfg(lim, dut, 2'(c));
      meas((lim + 1) * 4 * ps_f(2'(c)), dut * ps_f(2'(c)));
      rdc(`PWM_IDX_DHIGH, dut[9:2]);
      wr(`PWM_IDX_DHIGH, ~dut[9:2]);
      rdc(`PWM_IDX_DHIGH, dut[9:2]);
      apb(1'b0, `PWM_IDX_TCOUNT, 8'h00);
      check(rd <= lim, 1'b1);
    end
    // Duty changed mid-pulse applies from next period
    cfg(8'd15, 10'd40, 2'b01);
    meas(16 * 4 * 4, 40 * 4);
    wait_ev(rises, rises + 1);
    wr(`PWM_IDX_DLOW, 8'h02);
    wr(`PWM_IDX_MCTRL, 8'h0c);
    wait_ev(falls, falls + 1);
    check(hi_len, 40 * 4);
    meas(16 * 4 * 4, 8 * 4);
    // Duty beyond period keeps the pin high
    cfg(8'd3, 10'h3ff, 2'b00);
    repeat (40) @(posedge pclk);
    r0 = falls;
    repeat (64) @(posedge pclk);
    #1;
    check(falls, r0);
    check(level, 1'b1);
    // Zero duty never sets the pin
    cfg(8'd3, 10'h000, 2'b00);
    repeat (20) @(posedge pclk);
    r0 = rises;
    repeat (64) @(posedge pclk);
    #1;
    check(rises, r0);
    check(level, 1'b0);
    // Clearing control drops the latch and freezes the shadow
    cfg(8'd3, 10'd9, 2'b00);
    meas(16, 9);
    wr(`PWM_IDX_MCTRL, 8'h00);
    repeat (2) @(posedge pclk);
    #1;
    check(pwm_pin_o, 1'b0);
    check(pwm_pin_oe, 1'b0);
    wr(`PWM_IDX_DLOW, 8'h01);
    repeat (40) @(posedge pclk);
    rdc(`PWM_IDX_DHIGH, 8'h02);
    finish_test();
  end
endmodule : pwm_period_duty_generator_test
`default_nettype wire
